// ### core/pcl2_pkg.sv
package pcl2_pkg;
    // Byte addresses of the configuration registers inside the capability
    localparam logic [7:0]  DEV_CAP2_OFS      = 8'h24;
    localparam logic [7:0]  DEV_CTL2_OFS      = 8'h28;
    localparam logic [7:0]  LNK_CAP2_OFS      = 8'h2c;
    localparam logic [7:0]  LNK_CTL2_OFS      = 8'h30;
    localparam logic [7:0]  LNK_STS2_OFS      = 8'h32;

    // Device control 2 fields
    localparam int          CTO_VAL_LSB       = 0;
    localparam int          CTO_DIS_BIT       = 4;
    localparam logic [31:0] DEV_CTL2_WR_MASK  = 32'h0000_67f0 | 32'h0000_000f;
    localparam logic [31:0] DEV_CTL2_RESET    = 32'h0000_0000;

    // Device capabilities 2 fields
    localparam int          CTO_RANGES_LSB    = 0;
    localparam int          CTO_DIS_SUP_BIT   = 4;
    localparam int          ATOMIC_ROUTE_BIT  = 6;

    // Link capabilities 2 fields
    localparam int          SPEED_VEC_LSB     = 1;
    localparam logic [6:0]  SPEED_VEC_VALUE   = 7'h01;
    localparam logic [3:0]  MAX_LINK_SPEED    = 4'h1;

    // Link control 2 / status 2 fields (16-bit halves)
    localparam int          TGT_SPEED_LSB     = 0;
    localparam logic [3:0]  TGT_SPEED_RESET   = 4'h1;
    localparam int          WIDTH_LSB         = 4;
    localparam int          TRAIN_ERR_BIT     = 10;
    localparam int          TRAINING_BIT      = 11;
    localparam int          SLOT_CLK_BIT      = 12;
    localparam logic [5:0]  NEG_WIDTH_X1      = 6'h01;
    localparam logic [3:0]  CUR_SPEED_2G5     = 4'h1;

    // Completion timeout range bounds in microseconds
    localparam logic [31:0] US_50    = 32'h0000_0032;
    localparam logic [31:0] US_100   = 32'h0000_0064;
    localparam logic [31:0] MS_1     = 32'h0000_03e8;
    localparam logic [31:0] MS_10    = 32'h0000_2710;
    localparam logic [31:0] MS_16    = 32'h0000_3e80;
    localparam logic [31:0] MS_50    = 32'h0000_c350;
    localparam logic [31:0] MS_55    = 32'h0000_d6d8;
    localparam logic [31:0] MS_65    = 32'h0000_fde8;
    localparam logic [31:0] MS_210   = 32'h0003_3450;
    localparam logic [31:0] MS_260   = 32'h0003_f7a0;
    localparam logic [31:0] MS_900   = 32'h000d_bba0;
    localparam logic [31:0] S_1      = 32'h000f_4240;
    localparam logic [31:0] S_3P5    = 32'h0035_67e0;
    localparam logic [31:0] S_4      = 32'h003d_0900;
    localparam logic [31:0] S_13     = 32'h00c6_5d40;
    localparam logic [31:0] S_17     = 32'h0103_6640;
    localparam logic [31:0] S_64     = 32'h03d0_9000;

    typedef struct packed {
        logic training;
        logic train_err;
        logic l0_ok;
    } pcl2_link_evt_t;

    typedef struct packed {
        logic [31:0] min_us;
        logic [31:0] max_us;
        logic        disable_cto;
    } pcl2_cto_t;
endpackage : pcl2_pkg

// ### core/pcl2_train.sv
`timescale 1ns/1ps
`default_nettype none
module pcl2_train (
    input  wire logic                    i_mclk,
    input  wire logic                    i_arst_n,
    input  wire pcl2_pkg::pcl2_link_evt_t i_evt,
    output logic                         o_training,
    output logic                         o_train_err
);
    import pcl2_pkg::*;

    logic training_q;
    logic train_err_q;

    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            training_q <= 1'b1;
        end else begin
            training_q <= i_evt.training;
        end
    end

    // An error in the same cycle as L0 entry wins, so it is never lost
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            train_err_q <= 1'b0;
        end else if (i_evt.train_err) begin
            train_err_q <= 1'b1;
        end else if (i_evt.l0_ok && !i_evt.training) begin
            train_err_q <= 1'b0;
        end
    end

    assign o_training  = training_q;
    assign o_train_err = train_err_q;
endmodule : pcl2_train
`default_nettype wire

// ### core/pcl2_regs.sv
// Function
// - Completion timeout ranges field, device capabilities 2 bits 3:0, is read-only.
// - Completion timeout value resets to 0000b, the 50us to 50ms range.
// - Timeout value encodings decode to their fixed microsecond ranges.
// - Supported speeds vector bits 7:1 read-only, only 2.5 GT/s bit set.
// - AtomicOp routing supported bit 6 reads zero and is read-only.
// - Slot clock bit reads one with platform reference clock, else zero.
// - Link training bit is one while training runs, zero after success.
// - Training error sets on error, clears on normal L0 entry after training.
// - Negotiated link width always reads 000001b, single lane.
// - Current link speed reads 0001b, 2.5 GT/s.
// - Target link speed is writable storage; endpoint does not act on it.
// - Maximum link speed reports 0001b, consistent with the speeds vector.
`timescale 1ns/1ps
`default_nettype none
module pcl2_regs #(
    parameter logic [3:0] CTO_RANGES     = 4'h0,
    parameter logic       CTO_DIS_SUPPORT = 1'b0
) (
    input  wire logic                    i_mclk,
    input  wire logic                    i_arst_n,
    input  wire logic                    i_cfg_rd,
    input  wire logic                    i_cfg_wr,
    input  wire logic [7:0]              i_cfg_addr,
    input  wire logic [3:0]              i_cfg_be,
    input  wire logic [31:0]             i_cfg_wdata,
    output logic [31:0]                  o_cfg_rdata,
    output logic                         o_cfg_rvalid,
    input  wire logic                    i_slot_clk_strap,
    input  wire pcl2_pkg::pcl2_link_evt_t i_link_evt,
    output pcl2_pkg::pcl2_cto_t          o_cto,
    output logic [3:0]                   o_target_speed,
    output logic [3:0]                   o_max_link_speed
);
    import pcl2_pkg::*;

    logic [31:0] dev_ctl2_q;
    logic [3:0]  tgt_speed_q;
    logic        slot_clk_q;
    logic        slot_cap_done_q;
    logic [31:0] rdata_q;
    logic        rvalid_q;
    pcl2_cto_t   cto_q;
    logic        training;
    logic        train_err;
    logic [31:0] be_mask;
    logic [15:0] link_hw_bits;
    logic [31:0] dev_cap2;
    logic [31:0] lnk_cap2;
    logic [31:0] lnk_ctl_sts;

    function automatic logic [31:0] pcl2_be_mask(input logic [3:0] be);
        pcl2_be_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    endfunction : pcl2_be_mask

    function automatic logic [63:0] pcl2_cto_decode(input logic [3:0] code);
        case (code)
            4'h1:    pcl2_cto_decode = {US_50, US_100};
            4'h2:    pcl2_cto_decode = {MS_1, MS_10};
            4'h5:    pcl2_cto_decode = {MS_16, MS_55};
            4'h6:    pcl2_cto_decode = {MS_65, MS_210};
            4'h9:    pcl2_cto_decode = {MS_260, MS_900};
            4'ha:    pcl2_cto_decode = {S_1, S_3P5};
            4'hd:    pcl2_cto_decode = {S_4, S_13};
            4'he:    pcl2_cto_decode = {S_17, S_64};
            // Undefined codes fall back to the default range
            default: pcl2_cto_decode = {US_50, MS_50};
        endcase
    endfunction : pcl2_cto_decode

    pcl2_train u_train (
        .i_mclk      (i_mclk),
        .i_arst_n    (i_arst_n),
        .i_evt       (i_link_evt),
        .o_training  (training),
        .o_train_err (train_err)
    );

    assign be_mask = pcl2_be_mask(i_cfg_be);

    // Strap is caught once, on the first edge after reset release
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            slot_clk_q      <= 1'b0;
            slot_cap_done_q <= 1'b0;
        end else if (!slot_cap_done_q) begin
            slot_clk_q      <= i_slot_clk_strap;
            slot_cap_done_q <= 1'b1;
        end
    end

    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            dev_ctl2_q <= DEV_CTL2_RESET;
        end else if (i_cfg_wr && i_cfg_addr == DEV_CTL2_OFS) begin
            dev_ctl2_q <= (dev_ctl2_q & ~(be_mask & DEV_CTL2_WR_MASK))
                        | (i_cfg_wdata & be_mask & DEV_CTL2_WR_MASK);
        end
    end

    // Stored only; an endpoint never drives retraining from it
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            tgt_speed_q <= TGT_SPEED_RESET;
        end else if (i_cfg_wr && i_cfg_addr == LNK_CTL2_OFS && i_cfg_be[0]) begin
            tgt_speed_q <= i_cfg_wdata[TGT_SPEED_LSB +: 4];
        end
    end

    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            cto_q <= '0;
        end else begin
            {cto_q.min_us, cto_q.max_us} <= pcl2_cto_decode(dev_ctl2_q[CTO_VAL_LSB +: 4]);
            cto_q.disable_cto            <= dev_ctl2_q[CTO_DIS_BIT];
        end
    end

    always_comb begin
        link_hw_bits                          = 16'h0000;
        link_hw_bits[SLOT_CLK_BIT]            = slot_clk_q;
        link_hw_bits[TRAINING_BIT]            = training;
        link_hw_bits[TRAIN_ERR_BIT]           = train_err;
        link_hw_bits[WIDTH_LSB +: 6]          = NEG_WIDTH_X1;
        dev_cap2                              = 32'h0000_0000;
        dev_cap2[CTO_RANGES_LSB +: 4]         = CTO_RANGES;
        dev_cap2[CTO_DIS_SUP_BIT]             = CTO_DIS_SUPPORT;
        dev_cap2[ATOMIC_ROUTE_BIT]            = 1'b0;
        lnk_cap2                              = 32'h0000_0000;
        lnk_cap2[SPEED_VEC_LSB +: 7]          = SPEED_VEC_VALUE;
        lnk_ctl_sts                           = {link_hw_bits, link_hw_bits};
        lnk_ctl_sts[TGT_SPEED_LSB +: 4]       = tgt_speed_q;
        lnk_ctl_sts[16 + TGT_SPEED_LSB +: 4]  = CUR_SPEED_2G5;
    end

    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rdata_q  <= 32'h0000_0000;
            rvalid_q <= 1'b0;
        end else begin
            rvalid_q <= i_cfg_rd;
            if (i_cfg_rd) begin
                case (i_cfg_addr)
                    DEV_CAP2_OFS: rdata_q <= dev_cap2;
                    DEV_CTL2_OFS: rdata_q <= dev_ctl2_q;
                    LNK_CAP2_OFS: rdata_q <= lnk_cap2;
                    LNK_CTL2_OFS: rdata_q <= lnk_ctl_sts;
                    LNK_STS2_OFS: rdata_q <= {16'h0000, lnk_ctl_sts[31:16]};
                    default:      rdata_q <= 32'h0000_0000;
                endcase
            end
        end
    end

    assign o_cfg_rdata      = rdata_q;
    assign o_cfg_rvalid     = rvalid_q;
    assign o_cto            = cto_q;
    assign o_target_speed   = tgt_speed_q;
    assign o_max_link_speed = MAX_LINK_SPEED;
endmodule : pcl2_regs
`default_nettype wire

// ### tb/pcl2_ltssm.sv
`timescale 1ns/1ps
`default_nettype none
module pcl2_ltssm (
    input  wire logic                     i_mclk,
    input  wire logic                     i_arst_n,
    input  wire logic                     i_err,
    output pcl2_pkg::pcl2_link_evt_t      o_evt
);
    import pcl2_pkg::*;
    logic [4:0] cnt_q;
    // An error restarts training, as a real link would retrain
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) cnt_q <= 5'h00;
        else if (i_err) cnt_q <= 5'h00;
        else if (cnt_q != 5'h15) cnt_q <= cnt_q + 5'h01;
    end
    assign o_evt.training  = (cnt_q < 5'h14);
    assign o_evt.train_err = i_err;
    assign o_evt.l0_ok     = (cnt_q == 5'h14);
endmodule : pcl2_ltssm
`default_nettype wire

// ### tb/pcl2_regs_chk.sv
`timescale 1ns/1ps
`default_nettype none
module pcl2_regs_chk (
    input  wire logic                     i_mclk,
    input  wire logic                     i_arst_n,
    input  wire logic                     i_cfg_rd,
    input  wire logic                     i_cfg_wr,
    input  wire logic [7:0]               i_cfg_addr,
    input  wire logic [3:0]               i_cfg_be,
    input  wire logic [31:0]              i_cfg_wdata,
    input  wire logic [31:0]              o_cfg_rdata,
    input  wire logic                     o_cfg_rvalid,
    input  wire logic                     i_slot_clk_strap,
    input  wire pcl2_pkg::pcl2_link_evt_t i_link_evt,
    input  wire pcl2_pkg::pcl2_cto_t      o_cto,
    input  wire logic [3:0]               o_target_speed,
    input  wire logic [3:0]               o_max_link_speed
);
    import pcl2_pkg::*;
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_arst_n);
    wire rd_sts = i_cfg_rd && i_cfg_addr == LNK_STS2_OFS;
    property p_rvalid; o_cfg_rvalid == $past(i_cfg_rd); endproperty
    a_rvalid: assert property (p_rvalid) else $error("read valid not one cycle after read");
    property p_maxspd; o_max_link_speed == MAX_LINK_SPEED; endproperty
    a_maxspd: assert property (p_maxspd) else $error("max link speed wrong");
    property p_dcap; i_cfg_rd && i_cfg_addr == DEV_CAP2_OFS |=> o_cfg_rdata[31:5] == 27'h0; endproperty
    a_dcap: assert property (p_dcap) else $error("device cap2 upper bits set");
    property p_lcap; i_cfg_rd && i_cfg_addr == LNK_CAP2_OFS |=> o_cfg_rdata == 32'h0000_0002; endproperty
    a_lcap: assert property (p_lcap) else $error("speed vector wrong");
    property p_sts; rd_sts |=> o_cfg_rdata[9:0] == 10'h011 && o_cfg_rdata[31:13] == 19'h0; endproperty
    a_sts: assert property (p_sts) else $error("width or speed wrong");
    property p_train; rd_sts && i_link_evt.training && $past(i_link_evt.training) |=> o_cfg_rdata[11]; endproperty
    a_train: assert property (p_train) else $error("training bit low while training");
    property p_eset; rd_sts && $past(i_link_evt.train_err) |=> o_cfg_rdata[10]; endproperty
    a_eset: assert property (p_eset) else $error("training error not set");
    property p_eclr;
        rd_sts && $past(i_link_evt.l0_ok && !i_link_evt.training && !i_link_evt.train_err) |=> !o_cfg_rdata[10];
    endproperty
    a_eclr: assert property (p_eclr) else $error("training error not cleared");
    property p_cto;
        (i_cfg_wr && i_cfg_addr == DEV_CTL2_OFS && i_cfg_be[0] && i_cfg_wdata[3:0] == 4'h1) ##1 !i_cfg_wr
        |=> o_cto.min_us == US_50 && o_cto.max_us == US_100;
    endproperty
    a_cto: assert property (p_cto) else $error("timeout decode wrong");
    c_sts: cover property (rd_sts);
    c_wr: cover property (i_cfg_wr && i_cfg_addr == DEV_CTL2_OFS);
    c_err: cover property (i_link_evt.train_err);
endmodule : pcl2_regs_chk
bind pcl2_regs pcl2_regs_chk u_pcl2_regs_chk (.*);
`default_nettype wire

// ### tb/test_pcl2_regs.sv
`timescale 1ns/1ps
`default_nettype none
module test_pcl2_regs;
    import pcl2_pkg::*;
    logic clk = 0, rst_n = 0, rd = 0, wr = 0, err = 0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, d;
    logic rvalid;
    logic [3:0] tgt, mls;
    pcl2_link_evt_t evt;
    pcl2_cto_t cto;
    logic [31:0] q[$];
    int error_cnt = 0, n_checks = 0, cyc = 0;
    logic [3:0] codes[8] = '{4'h1, 4'h2, 4'h5, 4'h6, 4'h9, 4'ha, 4'hd, 4'he};
    logic [31:0] mins[8] = '{US_50, MS_1, MS_16, MS_65, MS_260, S_1, S_4, S_17};
    logic [31:0] maxs[8] = '{US_100, MS_10, MS_55, MS_210, MS_900, S_3P5, S_13, S_64};
    always #4 clk = ~clk;
    pcl2_ltssm u_pcl2_ltssm (.i_mclk(clk), .i_arst_n(rst_n), .i_err(err), .o_evt(evt));
    pcl2_regs u_pcl2_regs (.i_mclk(clk), .i_arst_n(rst_n), .i_cfg_rd(rd), .i_cfg_wr(wr), .i_cfg_addr(addr),
        .i_cfg_be(4'hf), .i_cfg_wdata(wdata), .o_cfg_rdata(rdata), .o_cfg_rvalid(rvalid),
        .i_slot_clk_strap(1'b1), .i_link_evt(evt), .o_cto(cto), .o_target_speed(tgt), .o_max_link_speed(mls));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] dat, input logic [31:0] e);
        @(posedge clk); #1;
        rd = !w; wr = w; addr = a; wdata = dat;
        if (!w) q.push_back(e);
        @(posedge clk); #1;
        rd = 0; wr = 0;
    endtask : acc
    task automatic test_done;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : test_done
    always @(negedge clk) if (rvalid === 1'b1) chk(rdata, q.pop_front());
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            error_cnt++;
            test_done;
        end
    end
    initial begin
        void'($urandom(94705));
        repeat (12) @(posedge clk);
        #1 rst_n = 1;
        @(posedge clk); #1;
        chk(cto.min_us, US_50);
        chk(cto.max_us, MS_50);
        acc(0, LNK_STS2_OFS, 0, 32'h0000_1811);
        @(posedge clk); #1 err = 1;
        @(posedge clk); #1 err = 0;
        acc(0, LNK_STS2_OFS, 0, 32'h0000_1c11);
        repeat (30) @(posedge clk);
        acc(0, LNK_STS2_OFS, 0, 32'h0000_1011);
        acc(1, LNK_STS2_OFS, 0, 0);
        acc(0, LNK_STS2_OFS, 0, 32'h0000_1011);
        acc(0, DEV_CTL2_OFS, 0, 32'h0);
        foreach (codes[i]) begin
            acc(1, DEV_CTL2_OFS, {28'h0, codes[i]}, 0);
            @(posedge clk); #1;
            chk(cto.min_us, mins[i]);
            chk(cto.max_us, maxs[i]);
            acc(0, DEV_CTL2_OFS, 0, {28'h0, codes[i]});
        end
        repeat (4) begin
            d = $urandom;
            acc(1, DEV_CTL2_OFS, d, 0);
            acc(0, DEV_CTL2_OFS, 0, d & DEV_CTL2_WR_MASK);
            chk({31'h0, cto.disable_cto}, {31'h0, d[4]});
        end
        acc(1, DEV_CAP2_OFS, 32'hffff_ffff, 0);
        acc(0, DEV_CAP2_OFS, 0, 32'h0);
        acc(1, LNK_CAP2_OFS, 32'hffff_ffff, 0);
        acc(0, LNK_CAP2_OFS, 0, 32'h0000_0002);
        acc(1, LNK_CTL2_OFS, 32'hffff_ffff, 0);
        chk({28'h0, tgt}, 32'hf);
        acc(0, LNK_CTL2_OFS, 0, 32'h1011_101f);
        chk({28'h0, mls}, 32'h1);
        acc(1, 8'h34, 32'hffff_ffff, 0);
        acc(0, 8'h34, 0, 32'h0);
        repeat (3) @(posedge clk);
        chk(q.size(), 0);
        test_done;
    end
endmodule : test_pcl2_regs
`default_nettype wire
